// file: mao_params.svh
// Width, depth and field constants for the memory access ordering unit
`ifndef MAO_PARAMS_SVH
`define MAO_PARAMS_SVH
`define MAO_AW 32
`define MAO_DW 32
`define MAO_SQ_DEPTH 4
`define MAO_SQ_IW 2
`define MAO_SQ_PW 3
`define MAO_SQ_FULL_CNT 3'h4
`define MAO_MTW 2
`define MAO_BKW 3
`define MAO_LSW 2
`define MAO_BSW 1
`endif

// file: mao_pkg.sv
// Types shared by the memory access ordering unit and its testbench
`include "mao_params.svh"
package mao_pkg;
	// Memory type tag carried by every access
	typedef enum logic [`MAO_MTW-1:0] {
		mt_cacheable = 2'h0,
		mt_wcomb = 2'h1,
		mt_strong = 2'h2
	} mem_type_t;
	// Barrier flavours
	typedef enum logic [`MAO_BKW-1:0] {
		load_barrier_op = 3'h0,
		store_barrier_op = 3'h1,
		full_barrier_op = 3'h2,
		serial_barrier_op = 3'h3,
		io_barrier_op = 3'h4,
		lock_barrier_op = 3'h5
	} barrier_kind_t;
	// Load port states
	typedef enum logic [`MAO_LSW-1:0] {
		ld_idle = 2'h0,
		ld_hold = 2'h1,
		ld_mem = 2'h2
	} ld_state_t;
	// Barrier sequencer states
	typedef enum logic [`MAO_BSW-1:0] {
		bar_idle = 1'h0,
		bar_wait = 1'h1
	} bar_state_t;
endpackage

// file: wc_merge_buffer.sv
// Single-entry write-combining buffer that merges writes to one word
`include "mao_params.svh"
module wc_merge_buffer (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	input wire logic [`MAO_AW-1:0] in_addr,
	input wire logic [`MAO_DW-1:0] in_data,
	output logic in_ready,
	input wire logic drain,
	output logic out_valid,
	output logic [`MAO_AW-1:0] out_addr,
	output logic [`MAO_DW-1:0] out_data,
	input wire logic out_ready,
	output logic held
);
	logic v; // Entry holds data
	logic next_v;
	logic [`MAO_AW-1:0] addr; // Word address of held data
	logic [`MAO_AW-1:0] next_addr;
	logic [`MAO_DW-1:0] data; // Merged data
	logic [`MAO_DW-1:0] next_data;

	// Handshakes and next entry state
	always_comb begin
		in_ready = !v || (addr == in_addr);
		out_valid = v && drain;
		out_addr = addr;
		out_data = data;
		held = v;
		next_v = v;
		next_addr = addr;
		next_data = data;
		// Drained entry leaves the buffer
		if (out_valid && out_ready) begin
			next_v = 1'b0;
		end
		// Same word overwrites: two writes become one
		if (in_valid && in_ready) begin
			next_v = 1'b1;
			next_addr = in_addr;
			next_data = in_data;
		end
	end

	// Entry registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			v <= 1'b0;
			addr <= 32'h0;
			data <= 32'h0;
		end else begin
			v <= next_v;
			addr <= next_addr;
			data <= next_data;
		end
	end
endmodule

// file: memory_access_ordering_unit.sv
// Load/store ordering unit: store queue, forwarding, write combining, barriers
`include "mao_params.svh"
module memory_access_ordering_unit (
	input wire logic clk,
	input wire logic rstn,
	input wire logic disp_valid,
	input wire logic [`MAO_AW-1:0] disp_addr,
	input wire mao_pkg::mem_type_t disp_mtype,
	input wire logic exe_valid,
	input wire logic [`MAO_SQ_IW-1:0] exe_idx,
	input wire logic [`MAO_DW-1:0] exe_data,
	input wire logic ret_valid,
	input wire logic ret_fault,
	input wire logic flush,
	input wire logic ld_valid,
	input wire logic [`MAO_AW-1:0] ld_addr,
	input wire mao_pkg::mem_type_t ld_mtype,
	input wire logic [`MAO_SQ_DEPTH-1:0] ld_older,
	input wire logic ld_oldest,
	input wire logic bar_valid,
	input wire mao_pkg::barrier_kind_t bar_kind,
	input wire logic mem_ready,
	input wire logic mem_rvalid,
	input wire logic [`MAO_DW-1:0] mem_rdata,
	output logic sq_full,
	output logic [`MAO_SQ_IW-1:0] sq_tail_idx,
	output logic exc_valid,
	output logic ld_busy,
	output logic ld_rsp_valid,
	output logic [`MAO_DW-1:0] ld_rsp_data,
	output logic ld_rsp_fwd,
	output logic bar_busy,
	output logic bar_done,
	output logic mem_valid,
	output logic mem_write,
	output logic [`MAO_AW-1:0] mem_addr,
	output logic [`MAO_DW-1:0] mem_wdata,
	output mao_pkg::mem_type_t mem_mtype
);
	// Store queue entries
	logic [`MAO_SQ_DEPTH-1:0] sq_v; // Entry allocated
	logic [`MAO_SQ_DEPTH-1:0] sq_exe; // Data present
	logic [`MAO_SQ_DEPTH-1:0] sq_com; // Retired, may drain
	logic [`MAO_AW-1:0] sq_addr [`MAO_SQ_DEPTH];
	logic [`MAO_DW-1:0] sq_data [`MAO_SQ_DEPTH];
	mao_pkg::mem_type_t sq_mt [`MAO_SQ_DEPTH];
	logic [`MAO_SQ_DEPTH-1:0] match; // Older same-address entries of held load
	// Queue pointers, one wrap bit above the index
	logic [`MAO_SQ_PW-1:0] head, tail, cptr;
	logic [`MAO_SQ_PW-1:0] next_head, next_tail, next_cptr;
	logic next_sq_full, next_exc_valid;
	logic [`MAO_SQ_IW-1:0] hidx, cidx;
	// Queue events this cycle
	logic alloc, commit_ok, raise, kill, pop;
	// Held load
	mao_pkg::ld_state_t ld_state, next_ld_state;
	logic [`MAO_AW-1:0] lq_addr, next_lq_addr;
	mao_pkg::mem_type_t lq_mt, next_lq_mt;
	logic [`MAO_SQ_DEPTH-1:0] lq_older, next_lq_older;
	logic lq_killed, next_lq_killed;
	logic next_ld_busy, next_rsp_valid, next_rsp_fwd;
	logic [`MAO_DW-1:0] next_rsp_data;
	// Load decisions
	logic one_m, fwd_ok, wc_hit, wr_fly, strong_wait, ld_fwd, ld_issue;
	logic [`MAO_SQ_IW-1:0] sel;
	// Memory request slot and drain paths
	logic slot_free, head_ready, head_st_ok, wc_force;
	logic next_mem_valid, next_mem_write;
	logic [`MAO_AW-1:0] next_mem_addr;
	logic [`MAO_DW-1:0] next_mem_wdata;
	mao_pkg::mem_type_t next_mem_mtype;
	// Combining buffer link
	logic wc_in_valid, wc_in_ready, wc_out_valid, wc_out_ready, wc_held;
	logic [`MAO_AW-1:0] wc_out_addr;
	logic [`MAO_DW-1:0] wc_out_data;
	// Barrier sequencer
	mao_pkg::bar_state_t bar_state, next_bar_state;
	mao_pkg::barrier_kind_t bar_q, next_bar_q;
	logic next_bar_busy, next_bar_done, need_ld, need_st, ld_done, st_done;

	// Queue-level events
	always_comb begin
		hidx = head[`MAO_SQ_IW-1:0];
		cidx = cptr[`MAO_SQ_IW-1:0];
		alloc = disp_valid && !sq_full && !bar_busy;
		commit_ok = ret_valid && !ret_fault && (cptr != tail) && sq_exe[cidx];
		raise = ret_valid && ret_fault && (cptr != tail);
		kill = flush || raise;
		next_head = head + {2'h0, pop};
		next_cptr = cptr + {2'h0, commit_ok};
		next_tail = kill ? next_cptr : tail + {2'h0, alloc};
		next_sq_full = (next_tail - next_head) == `MAO_SQ_FULL_CNT;
		next_exc_valid = raise;
	end

	// Per-entry state and address compare
	for (genvar i = 0; i < `MAO_SQ_DEPTH; i++) begin : g_sq
		logic nv, ne, nc;
		logic [`MAO_AW-1:0] na;
		logic [`MAO_DW-1:0] nd;
		mao_pkg::mem_type_t nm;
		// Older entry to the held load's word
		assign match[i] = sq_v[i] && lq_older[i] && (sq_addr[i] == lq_addr);
		// Next entry values
		always_comb begin
			nv = sq_v[i];
			ne = sq_exe[i];
			nc = sq_com[i];
			na = sq_addr[i];
			nd = sq_data[i];
			nm = sq_mt[i];
			// Allocation at dispatch, address and type known
			if (alloc && (tail[`MAO_SQ_IW-1:0] == i)) begin
				nv = 1'b1;
				ne = 1'b0;
				nc = 1'b0;
				na = disp_addr;
				nm = disp_mtype;
			end
			// Execution may come in any order, data only held here
			if (exe_valid && sq_v[i] && (exe_idx == i)) begin
				ne = 1'b1;
				nd = exe_data;
			end
			// Retirement marks entry as drainable
			if (commit_ok && (cidx == i)) begin
				nc = 1'b1;
			end
			// Uncommitted work is discarded on fault or flush
			if (kill && !nc) begin
				nv = 1'b0;
			end
			// Drained entry frees its slot
			if (pop && (hidx == i)) begin
				nv = 1'b0;
				nc = 1'b0;
			end
		end
		// Entry registers
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				sq_v[i] <= 1'b0;
				sq_exe[i] <= 1'b0;
				sq_com[i] <= 1'b0;
				sq_addr[i] <= 32'h0;
				sq_data[i] <= 32'h0;
				sq_mt[i] <= mao_pkg::mt_cacheable;
			end else begin
				sq_v[i] <= nv;
				sq_exe[i] <= ne;
				sq_com[i] <= nc;
				sq_addr[i] <= na;
				sq_data[i] <= nd;
				sq_mt[i] <= nm;
			end
		end
	end

	// Load hazard checks and forwarding choice
	always_comb begin
		sel = 2'h0;
		for (int k = 0; k < `MAO_SQ_DEPTH; k++) begin
			if (match[k]) begin
				sel = k[`MAO_SQ_IW-1:0];
			end
		end
		one_m = (match != 4'h0) && ((match & (match - 4'h1)) == 4'h0);
		// Single older match with data, both cacheable: bypass
		fwd_ok = one_m && sq_exe[sel] && (lq_mt == mao_pkg::mt_cacheable)
			&& (sq_mt[sel] == mao_pkg::mt_cacheable);
		wc_hit = wc_held && (wc_out_addr == lq_addr);
		wr_fly = mem_valid && mem_write && (mem_addr == lq_addr);
		// Strong loads: non-speculative, nothing older pending
		strong_wait = (lq_mt == mao_pkg::mt_strong)
			&& ((lq_older != 4'h0) || wc_held || mem_valid || !ld_oldest);
		slot_free = !mem_valid || mem_ready;
		ld_fwd = (ld_state == mao_pkg::ld_hold) && fwd_ok && !kill;
		// Other loads go at once, even past older stores to other words and on predicted paths
		ld_issue = (ld_state == mao_pkg::ld_hold) && (match == 4'h0) && !wc_hit && !wr_fly
			&& !strong_wait && slot_free && !kill;
	end

	// Load port sequencing
	always_comb begin
		next_ld_state = ld_state;
		next_lq_addr = lq_addr;
		next_lq_mt = lq_mt;
		next_lq_older = lq_older & ~({3'h0, pop} << hidx);
		next_lq_killed = lq_killed;
		next_rsp_valid = 1'b0;
		next_rsp_data = ld_rsp_data;
		next_rsp_fwd = 1'b0;
		case (ld_state)
			mao_pkg::ld_idle: begin
				// Younger loads are held off while a barrier runs
				if (ld_valid && !bar_busy) begin
					next_ld_state = mao_pkg::ld_hold;
					next_lq_addr = ld_addr;
					next_lq_mt = ld_mtype;
					next_lq_older = ld_older & sq_v;
					next_lq_killed = 1'b0;
				end
			end
			mao_pkg::ld_hold: begin
				// Flushed load is dropped silently
				if (kill) begin
					next_ld_state = mao_pkg::ld_idle;
				end else if (ld_fwd) begin
					next_ld_state = mao_pkg::ld_idle;
					next_rsp_valid = 1'b1;
					next_rsp_data = sq_data[sel];
					next_rsp_fwd = 1'b1;
				end else if (ld_issue) begin
					next_ld_state = mao_pkg::ld_mem;
				end
			end
			mao_pkg::ld_mem: begin
				// Flush after issue discards the answer
				if (kill) begin
					next_lq_killed = 1'b1;
				end
				if (mem_rvalid) begin
					next_ld_state = mao_pkg::ld_idle;
					next_rsp_valid = !(lq_killed || kill);
					next_rsp_data = mem_rdata;
				end
			end
			default: begin
				next_ld_state = mao_pkg::ld_idle;
			end
		endcase
		next_ld_busy = next_ld_state != mao_pkg::ld_idle;
	end

	// Store drain and memory request slot, loads first
	always_comb begin
		head_ready = sq_v[hidx] && sq_com[hidx];
		// Combining buffer emptied before a same-address or strong write
		wc_force = wc_held && (((bar_state == mao_pkg::bar_wait) && need_st)
			|| (head_ready && (sq_mt[hidx] == mao_pkg::mt_wcomb) && !wc_in_ready)
			|| (head_ready && (sq_mt[hidx] != mao_pkg::mt_wcomb)
				&& ((sq_addr[hidx] == wc_out_addr) || (sq_mt[hidx] == mao_pkg::mt_strong)))
			|| ((ld_state == mao_pkg::ld_hold) && (wc_hit || (lq_mt == mao_pkg::mt_strong)))
			|| (!head_ready && (ld_state == mao_pkg::ld_idle)));
		wc_in_valid = head_ready && (sq_mt[hidx] == mao_pkg::mt_wcomb) && !wc_force;
		wc_out_ready = slot_free && !ld_issue;
		// Cacheable writes may pass combined data of another address
		head_st_ok = head_ready && (sq_mt[hidx] != mao_pkg::mt_wcomb) && !wc_force
			&& slot_free && !ld_issue;
		pop = (wc_in_valid && wc_in_ready) || head_st_ok;
		next_mem_valid = mem_valid && !mem_ready;
		next_mem_write = mem_write;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_mtype = mem_mtype;
		if (ld_issue) begin
			next_mem_valid = 1'b1;
			next_mem_write = 1'b0;
			next_mem_addr = lq_addr;
			next_mem_mtype = lq_mt;
		end else if (wc_out_valid && wc_out_ready) begin
			next_mem_valid = 1'b1;
			next_mem_write = 1'b1;
			next_mem_addr = wc_out_addr;
			next_mem_wdata = wc_out_data;
			next_mem_mtype = mao_pkg::mt_wcomb;
		end else if (head_st_ok) begin
			next_mem_valid = 1'b1;
			next_mem_write = 1'b1;
			next_mem_addr = sq_addr[hidx];
			next_mem_wdata = sq_data[hidx];
			next_mem_mtype = sq_mt[hidx];
		end
	end

	// Combining buffer for write-combining stores
	wc_merge_buffer u_wc (
		.clk(clk),
		.rstn(rstn),
		.in_valid(wc_in_valid),
		.in_addr(sq_addr[hidx]),
		.in_data(sq_data[hidx]),
		.in_ready(wc_in_ready),
		.drain(wc_force),
		.out_valid(wc_out_valid),
		.out_addr(wc_out_addr),
		.out_data(wc_out_data),
		.out_ready(wc_out_ready),
		.held(wc_held)
	);

	// Barrier sequencer
	always_comb begin
		// Store barrier leaves loads free, load barrier leaves stores free, the rest cover both
		need_ld = bar_q != mao_pkg::store_barrier_op;
		need_st = bar_q != mao_pkg::load_barrier_op;
		ld_done = (ld_state == mao_pkg::ld_idle) && !(mem_valid && !mem_write);
		st_done = (head == tail) && !wc_held && !(mem_valid && mem_write);
		next_bar_state = bar_state;
		next_bar_q = bar_q;
		next_bar_done = 1'b0;
		case (bar_state)
			mao_pkg::bar_idle: begin
				if (bar_valid) begin
					next_bar_state = mao_pkg::bar_wait;
					next_bar_q = bar_kind;
				end
			end
			mao_pkg::bar_wait: begin
				// Release only once every older covered access is done
				if ((!need_ld || ld_done) && (!need_st || st_done)) begin
					next_bar_state = mao_pkg::bar_idle;
					next_bar_done = 1'b1;
				end
			end
			default: begin
				next_bar_state = mao_pkg::bar_idle;
			end
		endcase
		next_bar_busy = next_bar_state == mao_pkg::bar_wait;
	end

	// State and output registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			head <= 3'h0;
			tail <= 3'h0;
			cptr <= 3'h0;
			sq_full <= 1'b0;
			sq_tail_idx <= 2'h0;
			exc_valid <= 1'b0;
			ld_state <= mao_pkg::ld_idle;
			lq_addr <= 32'h0;
			lq_mt <= mao_pkg::mt_cacheable;
			lq_older <= 4'h0;
			lq_killed <= 1'b0;
			ld_busy <= 1'b0;
			ld_rsp_valid <= 1'b0;
			ld_rsp_data <= 32'h0;
			ld_rsp_fwd <= 1'b0;
			mem_valid <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 32'h0;
			mem_wdata <= 32'h0;
			mem_mtype <= mao_pkg::mt_cacheable;
			bar_state <= mao_pkg::bar_idle;
			bar_q <= mao_pkg::load_barrier_op;
			bar_busy <= 1'b0;
			bar_done <= 1'b0;
		end else begin
			head <= next_head;
			tail <= next_tail;
			cptr <= next_cptr;
			sq_full <= next_sq_full;
			sq_tail_idx <= next_tail[`MAO_SQ_IW-1:0];
			exc_valid <= next_exc_valid;
			ld_state <= next_ld_state;
			lq_addr <= next_lq_addr;
			lq_mt <= next_lq_mt;
			lq_older <= next_lq_older;
			lq_killed <= next_lq_killed;
			ld_busy <= next_ld_busy;
			ld_rsp_valid <= next_rsp_valid;
			ld_rsp_data <= next_rsp_data;
			ld_rsp_fwd <= next_rsp_fwd;
			mem_valid <= next_mem_valid;
			mem_write <= next_mem_write;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_mtype <= next_mem_mtype;
			bar_state <= next_bar_state;
			bar_q <= next_bar_q;
			bar_busy <= next_bar_busy;
			bar_done <= next_bar_done;
		end
	end
endmodule

// file: mao_order_checker.sv
// Port-level ordering checks for the ordering unit
`include "mao_params.svh"
module mao_order_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic disp_valid,
	input wire logic ret_valid,
	input wire logic ret_fault,
	input wire logic flush,
	input wire logic ld_valid,
	input wire logic bar_valid,
	input wire logic mem_ready,
	input wire logic mem_rvalid,
	input wire logic sq_full,
	input wire logic [`MAO_SQ_IW-1:0] sq_tail_idx,
	input wire logic exc_valid,
	input wire logic ld_busy,
	input wire logic ld_rsp_valid,
	input wire logic ld_rsp_fwd,
	input wire logic bar_busy,
	input wire logic bar_done,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [`MAO_AW-1:0] mem_addr,
	input wire logic [`MAO_DW-1:0] mem_wdata
);
	// Core clock and reset for every check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Accepted store takes the next index
	property p_disp;
		disp_valid && !sq_full && !bar_busy && !flush && !ret_fault |=> sq_tail_idx == $past(sq_tail_idx) + 2'h1;
	endproperty
	a_disp: assert property (p_disp) else $error("store index did not advance");
	// Full queue refuses new stores
	property p_full; sq_full && !flush && !ret_fault |=> $stable(sq_tail_idx); endproperty
	a_full: assert property (p_full) else $error("full queue took a store");
	// Fault only for a faulting retirement
	property p_exc; exc_valid |-> $past(ret_fault, 1) || $past(ret_fault, 2); endproperty
	a_exc: assert property (p_exc) else $error("fault without faulting retire");
	// Free load port takes a load
	property p_ld; ld_valid && !ld_busy && !bar_busy |=> ld_busy; endproperty
	a_ld: assert property (p_ld) else $error("load not taken");
	// Barrier taken at once
	property p_bar; bar_valid && !bar_busy |=> bar_busy; endproperty
	a_bar: assert property (p_bar) else $error("barrier not taken");
	// Completion pulse marks the end of a barrier
	property p_done; bar_done == $fell(bar_busy); endproperty
	a_done: assert property (p_done) else $error("barrier done misplaced");
	// No younger load starts under a barrier
	property p_bar_ld; bar_busy && !ld_busy |=> !ld_busy; endproperty
	a_bar_ld: assert property (p_bar_ld) else $error("load started under barrier");
	// Answers come from memory or from the queue
	property p_rsp; ld_rsp_valid |-> $past(mem_rvalid) || ld_rsp_fwd; endproperty
	a_rsp: assert property (p_rsp) else $error("load answer without source");
	// Forward flag only with an answer
	property p_fwd; ld_rsp_fwd |-> ld_rsp_valid; endproperty
	a_fwd: assert property (p_fwd) else $error("forward flag alone");
	// Memory request stands until accepted
	property p_hold;
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_write) && $stable(mem_wdata);
	endproperty
	a_hold: assert property (p_hold) else $error("memory request changed early");
	// Main scenarios reached
	c_fwd: cover property (ld_rsp_fwd);
	c_exc: cover property (exc_valid);
	c_done: cover property (bar_done);
	c_wr: cover property (mem_valid && mem_write && mem_ready);
endmodule

// file: mem_model.sv
// Behavioural memory answering the ordering unit's requests
`include "mao_params.svh"
module mem_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [`MAO_AW-1:0] mem_addr,
	input wire logic [`MAO_DW-1:0] mem_wdata,
	output logic mem_ready,
	output logic mem_rvalid,
	output logic [`MAO_DW-1:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt; // Free count for slow accepts
	logic [1:0] rpend; // Read answer delay line
	logic [`MAO_DW-1:0] rdat; // Data picked for the accepted read
	int wr_cnt; // Writes accepted
	logic [`MAO_AW-1:0] wa_q[$]; // Write address log
	logic [`MAO_DW-1:0] wd_q[$]; // Write data log
	// Last logged write to a word, else a pattern from its address
	function automatic logic [`MAO_DW-1:0] look(input logic [`MAO_AW-1:0] a);
		look = a ^ 32'h5a5a5a5a;
		for (int j = 0; j < wa_q.size(); j++) begin
			if (wa_q[j] == a) begin
				look = wd_q[j];
			end
		end
	endfunction
	// Accept every cycle, or one in four when slow
	assign mem_ready = !slow || (cnt == 2'h3);
	// Log writes, answer reads late, scramble idle data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 2'h0;
			rpend <= 2'h0;
			mem_rvalid <= 1'h0;
			mem_rdata <= 32'h0;
		end else begin
			cnt <= cnt + 2'h1;
			rpend <= {rpend[0], mem_valid && mem_ready && !mem_write};
			mem_rvalid <= rpend[1];
			mem_rdata <= rpend[1] ? rdat : ~mem_rdata;
			if (mem_valid && mem_ready && !mem_write) rdat <= look(mem_addr);
			if (mem_valid && mem_ready && mem_write) begin
				wr_cnt <= wr_cnt + 1;
				wa_q.push_back(mem_addr);
				wd_q.push_back(mem_wdata);
			end
		end
	end
endmodule

// file: tb_memory_access_ordering_unit.sv
// Self-checking bench for the ordering unit with a behavioural memory
`include "mao_params.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", n, e, g); error_cnt++; end end
module tb_memory_access_ordering_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, disp_valid, exe_valid, ret_valid, ret_fault, flush, ld_valid, ld_oldest, bar_valid, slow;
	logic [`MAO_AW-1:0] disp_addr, ld_addr, mem_addr;
	logic [`MAO_DW-1:0] exe_data, mem_rdata, mem_wdata, ld_rsp_data, d;
	logic [`MAO_SQ_IW-1:0] exe_idx, sq_tail_idx;
	logic [`MAO_SQ_DEPTH-1:0] ld_older;
	logic mem_ready, mem_rvalid, sq_full, exc_valid, ld_busy, ld_rsp_valid, ld_rsp_fwd, bar_busy, bar_done;
	logic mem_valid, mem_write, f;
	mao_pkg::mem_type_t disp_mtype, ld_mtype, mem_mtype;
	mao_pkg::barrier_kind_t bar_kind;
	int error_cnt, n_tests, n_rsp, n_exc, w;
	memory_access_ordering_unit memory_access_ordering_unit_inst (.clk(clk), .rstn(rstn), .disp_valid(disp_valid),
		.disp_addr(disp_addr), .disp_mtype(disp_mtype), .exe_valid(exe_valid), .exe_idx(exe_idx), .exe_data(exe_data),
		.ret_valid(ret_valid), .ret_fault(ret_fault), .flush(flush), .ld_valid(ld_valid), .ld_addr(ld_addr),
		.ld_mtype(ld_mtype), .ld_older(ld_older), .ld_oldest(ld_oldest), .bar_valid(bar_valid), .bar_kind(bar_kind),
		.mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .sq_full(sq_full),
		.sq_tail_idx(sq_tail_idx), .exc_valid(exc_valid), .ld_busy(ld_busy), .ld_rsp_valid(ld_rsp_valid),
		.ld_rsp_data(ld_rsp_data), .ld_rsp_fwd(ld_rsp_fwd), .bar_busy(bar_busy), .bar_done(bar_done),
		.mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_mtype(mem_mtype));
	mem_model mem_model_inst (.clk(clk), .rstn(rstn), .slow(slow), .mem_valid(mem_valid), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata));
	// Verdict and end of run
	task automatic complete_run();
		if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Ran out of patience
	task automatic chk_to(input int i);
		if (i >= 300) begin
			$display("BAD wait exp done got none");
			error_cnt++;
			complete_run();
		end
	endtask
	// Dispatch one store
	task automatic disp(input logic [`MAO_AW-1:0] a, input mao_pkg::mem_type_t m);
		disp_valid = 1'h1;
		disp_addr = a;
		disp_mtype = m;
		@(negedge clk);
		disp_valid = 1'h0;
		@(negedge clk);
	endtask
	// Report store data as executed
	task automatic exe(input logic [`MAO_SQ_IW-1:0] i, input logic [`MAO_DW-1:0] v);
		exe_valid = 1'h1;
		exe_idx = i;
		exe_data = v;
		@(negedge clk);
		exe_valid = 1'h0;
		@(negedge clk);
	endtask
	// Retire n stores back to back
	task automatic ret(input int n, input logic flt);
		ret_valid = 1'h1;
		ret_fault = flt;
		repeat (n) @(negedge clk);
		ret_valid = 1'h0;
		ret_fault = 1'h0;
		@(negedge clk);
	endtask
	// Offer one load
	task automatic ld_req(input logic [`MAO_AW-1:0] a, input mao_pkg::mem_type_t m, input logic [3:0] o);
		ld_valid = 1'h1;
		ld_addr = a;
		ld_mtype = m;
		ld_older = o;
		@(negedge clk);
		ld_valid = 1'h0;
	endtask
	// Wait for a further load answer
	task automatic ld_wait(input int g);
		int i;
		for (i = 0; i < 300 && n_rsp == g; i++) @(negedge clk);
		chk_to(i);
	endtask
	// Run one barrier to its end
	task automatic bar(input mao_pkg::barrier_kind_t k);
		int i;
		bar_valid = 1'h1;
		bar_kind = k;
		@(negedge clk);
		bar_valid = 1'h0;
		for (i = 0; i < 300 && bar_done !== 1'h1; i++) @(negedge clk);
		chk_to(i);
		@(negedge clk);
	endtask
	// Capture load answers and faults as they pass
	always @(negedge clk) begin
		if (ld_rsp_valid === 1'h1) begin
			d = ld_rsp_data;
			f = ld_rsp_fwd;
			n_rsp++;
		end
		if (exc_valid === 1'h1) n_exc++;
	end
	// Same-word load stalls, then takes the store data
	task automatic s_fwd();
		disp(32'h10, mao_pkg::mt_cacheable);
		ld_req(32'h10, mao_pkg::mt_cacheable, 4'h1);
		repeat (6) @(negedge clk);
		`CHK("stall", 1'h1, ld_busy)
		exe(2'h0, 32'hcafe0001);
		ld_wait(0);
		`CHK("fwd_data", 32'hcafe0001, d)
		`CHK("fwd_flag", 1'h1, f)
	endtask
	// Stores executed out of order stay hidden, then drain in order
	task automatic s_commit();
		disp(32'h20, mao_pkg::mt_cacheable);
		disp(32'h30, mao_pkg::mt_cacheable);
		exe(2'h2, 32'hcafe0003);
		exe(2'h1, 32'hcafe0002);
		repeat (8) @(negedge clk);
		`CHK("early_wr", 0, mem_model_inst.wr_cnt)
		slow = 1'h1;
		ret(3, 1'h0);
		w = n_rsp;
		ld_req(32'h10, mao_pkg::mt_cacheable, 4'h7);
		ld_wait(w);
		`CHK("buf_read", 32'hcafe0001, d)
		bar(mao_pkg::store_barrier_op);
		slow = 1'h0;
		`CHK("wr_cnt", 3, mem_model_inst.wr_cnt)
		for (int i = 0; i < 3; i++) begin
			`CHK("wr_addr", 32'h10 + 32'h10 * i, mem_model_inst.wa_q[i])
			`CHK("wr_data", 32'hcafe0001 + i, mem_model_inst.wd_q[i])
		end
	endtask
	// Faulting retire raises and drops the store
	task automatic s_fault();
		disp(32'h40, mao_pkg::mt_cacheable);
		exe(2'h3, 32'hdead0004);
		ret(1, 1'h1);
		@(negedge clk);
		`CHK("exc", 1, n_exc)
		`CHK("tail", 2'h3, sq_tail_idx)
		bar(mao_pkg::store_barrier_op);
		`CHK("no_wr", 3, mem_model_inst.wr_cnt)
	endtask
	// Combining writes end with the last value
	task automatic s_wc();
		disp(32'h60, mao_pkg::mt_wcomb);
		disp(32'h60, mao_pkg::mt_wcomb);
		exe(2'h3, 32'h1111);
		exe(2'h0, 32'h2222);
		ret(2, 1'h0);
		bar(mao_pkg::store_barrier_op);
		`CHK("wc_data", 32'h2222, mem_model_inst.wd_q[$])
		`CHK("wc_merge", 4, mem_model_inst.wr_cnt)
	endtask
	// Full queue refuses, flush discards speculative stores
	task automatic s_full();
		w = mem_model_inst.wr_cnt;
		for (int i = 0; i < 5; i++) disp(32'h100 + i, mao_pkg::mt_cacheable);
		`CHK("full", 1'h1, sq_full)
		`CHK("full_tail", 2'h1, sq_tail_idx)
		exe(2'h1, 32'h77);
		flush = 1'h1;
		@(negedge clk);
		flush = 1'h0;
		bar(mao_pkg::full_barrier_op);
		`CHK("spec_wr", w, mem_model_inst.wr_cnt)
		`CHK("flush_tail", 2'h1, sq_tail_idx)
	endtask
	// Plain, strong and fenced loads
	task automatic s_loads();
		w = n_rsp;
		ld_req(32'h70, mao_pkg::mt_cacheable, 4'h0);
		ld_wait(w);
		`CHK("ld_data", 32'h70 ^ 32'h5a5a5a5a, d)
		`CHK("ld_fwd", 1'h0, f)
		w = n_rsp;
		ld_req(32'h80, mao_pkg::mt_strong, 4'h0);
		repeat (8) @(negedge clk);
		`CHK("strong_wait", 1'h1, ld_busy)
		ld_oldest = 1'h1;
		ld_wait(w);
		`CHK("strong_data", 32'h80 ^ 32'h5a5a5a5a, d)
		`CHK("strong_type", mao_pkg::mt_strong, mem_mtype)
		slow = 1'h1;
		ld_req(32'h90, mao_pkg::mt_cacheable, 4'h0);
		bar(mao_pkg::load_barrier_op);
		`CHK("ld_fence", 1'h0, ld_busy)
		slow = 1'h0;
	endtask
	// Every barrier kind completes
	task automatic s_barriers();
		for (int k = 0; k < 6; k++) begin
			bar(mao_pkg::barrier_kind_t'(k));
			`CHK("bar_end", 1'h0, bar_busy)
		end
	endtask
	// Clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Reset, then the scenarios
	initial begin
		{rstn, disp_valid, exe_valid, ret_valid, ret_fault, flush, ld_valid, ld_oldest, bar_valid, slow} = '0;
		{disp_addr, ld_addr, exe_data, exe_idx, ld_older} = '0;
		disp_mtype = mao_pkg::mt_cacheable;
		ld_mtype = mao_pkg::mt_cacheable;
		bar_kind = mao_pkg::load_barrier_op;
		repeat (4) @(negedge clk);
		rstn = 1'h1;
		@(negedge clk);
		s_fwd();
		s_commit();
		s_fault();
		s_wc();
		s_full();
		s_loads();
		s_barriers();
		complete_run();
	end
endmodule
bind memory_access_ordering_unit mao_order_checker mao_order_checker_inst (.clk(clk), .rstn(rstn),
	.disp_valid(disp_valid), .ret_valid(ret_valid), .ret_fault(ret_fault), .flush(flush), .ld_valid(ld_valid),
	.bar_valid(bar_valid), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .sq_full(sq_full),
	.sq_tail_idx(sq_tail_idx), .exc_valid(exc_valid), .ld_busy(ld_busy), .ld_rsp_valid(ld_rsp_valid),
	.ld_rsp_fwd(ld_rsp_fwd), .bar_busy(bar_busy), .bar_done(bar_done), .mem_valid(mem_valid),
	.mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
